// ==== hw/dpps_sequencer.sv ====
// Purpose: reset, init, FPGA setup and park sequencing of the display controller
// Assumes: all pin inputs asynchronous to mclk; ledSelectReq comes from mclk logic
// Notes: long counts are parameters so simulation can shorten them
`timescale 1ns/100ps
`default_nettype none

// Operation
// - on core power loss, host-supply outputs go high impedance.
// - rising edge of reset input starts automatic initialization.
// - host interrupt driven low when initialization finishes.
// - boot from reset release to done takes about 100 ms.
// - high resolution: write FPGA startup values 2.75 ms, then accept I2C.
// - projector enable falling starts normal park, done within 20 ms; code ignores a fall during boot or in the cycle fpgaReady is seen.
// - after park, reset asserted; device releases host interrupt line.
// - high resolution: regulation stops 12 ms after normal park completes.
// - fast-park request low starts fast park immediately.
// - host interrupt driven high right after reset release.
// - in reset: flash and GPIO tri-stated, LED select and mirror reset low.
module dpps_sequencer
  import dpps_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES,
  parameter int unsigned NPARK_LEN = NPARK_CYCLES,
  parameter int unsigned FPARK_LEN = FPARK_CYCLES,
  parameter int unsigned REG_STOP_LEN = REG_STOP_CYCLES,
  parameter int unsigned FPGA_SETUP_LEN = FPGA_SETUP_CYCLES
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic activeLowResetIn,
  input wire logic fastParkRequestN,
  input wire logic projectorEnable,
  input wire logic coreSupplyGood,
  input wire logic highResolutionMode,
  input wire logic fpgaReady,
  input wire logic [1:0] ledSelectReq,
  output logic hostIrqOut,
  output logic hostIrqOe,
  output logic flashOe,
  output logic gpioOe,
  output logic [1:0] ledSelectBits,
  output logic mirrorArrayResetOut,
  output logic parkActive,
  output logic regulationOn,
  output logic fpgaSetupActive,
  output logic i2cAccept,
  output logic initDone
);
  if (BOOT_LEN < 1 || NPARK_LEN < 1 || FPARK_LEN < 1 || REG_STOP_LEN < 1 ||
      FPGA_SETUP_LEN < 1)
  begin : g_chk
    $error("dpps_sequencer: every cycle count must be at least one");
  end
  typedef struct packed {
    dpps_pins_type pinMeta;
    dpps_pins_type pinSync;
    dpps_pins_type pinPrev;
    dpps_state_type state;
    logic [CNT_W-1:0] cnt;
    logic hiRes;
    logic regRun;
    dpps_outs_type o;
  } dpps_regs_type;
  logic [1:0] rstSync_r;
  logic rstN;
  dpps_regs_type st_r;
  dpps_regs_type st_nxt;
  dpps_pins_type pinsIn;
  logic rstRise;
  logic projFall;
  logic active;

  // reset release through two flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync_r <= RST_SYNC_RST;
    end
    else
    begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  assign pinsIn = '{coreGood: coreSupplyGood, rstIn: activeLowResetIn,
                    parkN: fastParkRequestN, projEn: projectorEnable,
                    hiRes: highResolutionMode, fpgaRdy: fpgaReady};

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pinMeta = pinsIn;
    st_nxt.pinSync = st_r.pinMeta;
    st_nxt.pinPrev = st_r.pinSync;
    st_nxt.cnt = st_r.cnt + CNT_W'(1);
    rstRise = st_r.pinSync.rstIn && !st_r.pinPrev.rstIn;
    projFall = !st_r.pinSync.projEn && st_r.pinPrev.projEn;
    active = (st_r.state == ST_BOOT) || (st_r.state == ST_FPGA_WAIT) ||
             (st_r.state == ST_FPGA_SETUP) || (st_r.state == ST_RUN) ||
             (st_r.state == ST_NPARK);
    if (!st_r.pinSync.rstIn)
    begin
      st_nxt.state = ST_OFF;
      st_nxt.cnt = '0;
      st_nxt.regRun = 1'b0;
    end
    else if (!st_r.pinSync.parkN && active)
    begin
      st_nxt.state = ST_FPARK;
      st_nxt.cnt = '0;
    end
    else
    begin
      case (st_r.state)
        ST_OFF:
        begin
          st_nxt.cnt = '0;
          if (rstRise)
          begin
            st_nxt.state = ST_BOOT;
            st_nxt.hiRes = st_r.pinSync.hiRes;
          end
        end
        ST_BOOT:
        begin
          if (st_r.cnt == CNT_W'(BOOT_LEN - 1))
          begin
            st_nxt.state = st_r.hiRes ? ST_FPGA_WAIT : ST_RUN;
            st_nxt.cnt = '0;
          end
        end
        ST_FPGA_WAIT:
        begin
          st_nxt.cnt = '0;
          if (st_r.pinSync.fpgaRdy)
          begin
            st_nxt.state = ST_FPGA_SETUP;
          end
          else if (projFall)
          begin
            st_nxt.state = ST_NPARK;
          end
        end
        ST_FPGA_SETUP:
        begin
          if (projFall)
          begin
            st_nxt.state = ST_NPARK;
            st_nxt.cnt = '0;
          end
          else if (st_r.cnt == CNT_W'(FPGA_SETUP_LEN - 1))
          begin
            st_nxt.state = ST_RUN;
            st_nxt.cnt = '0;
          end
        end
        ST_RUN:
        begin
          st_nxt.cnt = '0;
          if (projFall)
          begin
            st_nxt.state = ST_NPARK;
          end
        end
        ST_NPARK:
        begin
          if (st_r.cnt == CNT_W'(NPARK_LEN - 1))
          begin
            st_nxt.state = ST_PARKED;
            st_nxt.cnt = '0;
            st_nxt.regRun = st_r.hiRes;
          end
        end
        ST_FPARK:
        begin
          if (st_r.cnt == CNT_W'(FPARK_LEN - 1))
          begin
            st_nxt.state = ST_PARKED;
            st_nxt.cnt = '0;
            st_nxt.regRun = 1'b0;
          end
        end
        default:
        begin
          if (!st_r.regRun)
          begin
            st_nxt.cnt = st_r.cnt;
          end
          else if (st_r.cnt == CNT_W'(REG_STOP_LEN - 1))
          begin
            st_nxt.regRun = 1'b0;
          end
        end
      endcase
    end
    // outputs follow the next state so they line up with st_r.state
    st_nxt.o = OUTS_RST;
    if (st_nxt.state != ST_OFF)
    begin
      st_nxt.o.flashOe = 1'b1;
      st_nxt.o.gpioOe = 1'b1;
      st_nxt.o.ledSelect = ledSelectReq;
      st_nxt.o.hostIrqOe = st_r.pinSync.coreGood;
      st_nxt.o.hostIrqOut = (st_nxt.state == ST_BOOT);
      st_nxt.o.initDone = (st_nxt.state != ST_BOOT);
      st_nxt.o.mirrorArrayResetOut = (st_nxt.state != ST_PARKED);
      st_nxt.o.parkActive = (st_nxt.state == ST_NPARK) || (st_nxt.state == ST_FPARK);
      st_nxt.o.regulationOn = (st_nxt.state != ST_PARKED) || st_nxt.regRun;
      st_nxt.o.fpgaSetupActive = (st_nxt.state == ST_FPGA_SETUP);
      st_nxt.o.i2cAccept = (st_nxt.state == ST_RUN);
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_r <= '{pinMeta: PINS_RST, pinSync: PINS_RST, pinPrev: PINS_RST, state: ST_OFF,
                cnt: '0, hiRes: 1'b0, regRun: 1'b0, o: OUTS_RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hostIrqOut = st_r.o.hostIrqOut;
  assign hostIrqOe = st_r.o.hostIrqOe;
  assign flashOe = st_r.o.flashOe;
  assign gpioOe = st_r.o.gpioOe;
  assign ledSelectBits = st_r.o.ledSelect;
  assign mirrorArrayResetOut = st_r.o.mirrorArrayResetOut;
  assign parkActive = st_r.o.parkActive;
  assign regulationOn = st_r.o.regulationOn;
  assign fpgaSetupActive = st_r.o.fpgaSetupActive;
  assign i2cAccept = st_r.o.i2cAccept;
  assign initDone = st_r.o.initDone;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  boot_start_a: assert property (
    st_r.state == ST_OFF && rstRise |=> st_r.state == ST_BOOT && hostIrqOut)
    else $error("reset rise did not start boot");
  irq_boot_high_a: assert property (
    st_r.state == ST_BOOT && st_r.pinPrev.coreGood |-> hostIrqOe && hostIrqOut)
    else $error("interrupt not high during boot");
  irq_done_low_a: assert property (
    $fell(st_r.state == ST_BOOT) && st_r.pinSync.rstIn |-> !hostIrqOut && initDone)
    else $error("interrupt not low after boot");
  core_loss_a: assert property (
    !st_r.pinPrev.coreGood |-> !hostIrqOe)
    else $error("interrupt driven without core power");
  reset_off_a: assert property (
    !st_r.pinSync.rstIn |=> st_r.state == ST_OFF && !hostIrqOe)
    else $error("interrupt still driven in reset");
  reset_pins_a: assert property (
    st_r.state == ST_OFF |-> !flashOe && !gpioOe && ledSelectBits == 2'h0 &&
      !mirrorArrayResetOut)
    else $error("pins active in reset");
  npark_entry_a: assert property (
    st_r.state == ST_RUN && projFall && st_r.pinSync.rstIn && st_r.pinSync.parkN
      |=> st_r.state == ST_NPARK && parkActive)
    else $error("normal park not started");
  npark_bound_a: assert property (
    st_r.state == ST_NPARK |-> st_r.cnt < CNT_W'(NPARK_LEN))
    else $error("normal park overran");
  fast_park_a: assert property (
    active && !st_r.pinSync.parkN && st_r.pinSync.rstIn |=> st_r.state == ST_FPARK)
    else $error("fast park not started");
  i2c_gate_a: assert property (
    $rose(i2cAccept) && st_r.hiRes |-> $past(st_r.state) == ST_FPGA_SETUP)
    else $error("I2C accepted before FPGA setup");
  reg_stop_a: assert property (
    st_r.state == ST_PARKED && regulationOn |-> st_r.hiRes &&
      st_r.cnt < CNT_W'(REG_STOP_LEN))
    else $error("regulation running too long");

  boot_done_c: cover property (st_r.state == ST_BOOT ##1 st_r.state == ST_RUN);
  setup_done_c: cover property (st_r.state == ST_FPGA_SETUP ##1 st_r.state == ST_RUN);
  npark_done_c: cover property (st_r.state == ST_NPARK ##1 st_r.state == ST_PARKED);
  fpark_done_c: cover property (st_r.state == ST_FPARK ##1 st_r.state == ST_PARKED);
endmodule

`default_nettype wire

// ==== hw/dpps_pkg.sv ====
// Purpose: shared constants and types for the display power/park sequencer
// Assumes: core clock mclk at 250 MHz
// Notes: times kept in their own unit, cycle counts derived from the clock rate
package dpps_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 32;
  // automatic initialization, typical boot
  localparam int BOOT_TIME_US = 100000;
  localparam int BOOT_CYCLES = BOOT_TIME_US * CLK_MHZ;
  // normal park must finish within this time (longest time, rounds down)
  localparam int NPARK_TIME_US = 20000;
  localparam int NPARK_CYCLES = NPARK_TIME_US * CLK_MHZ;
  // fast park hold-up window
  localparam int FPARK_TIME_US = 32;
  localparam int FPARK_CYCLES = FPARK_TIME_US * CLK_MHZ;
  // mirror reset voltage regulation stop after normal park (high resolution)
  localparam int REG_STOP_TIME_US = 12000;
  localparam int REG_STOP_CYCLES = REG_STOP_TIME_US * CLK_MHZ;
  // companion FPGA setup phase
  localparam int FPGA_SETUP_TIME_NS = 2750000;
  localparam int FPGA_SETUP_CYCLES = FPGA_SETUP_TIME_NS / 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_OFF, ST_BOOT, ST_FPGA_WAIT, ST_FPGA_SETUP, ST_RUN, ST_NPARK, ST_FPARK, ST_PARKED
  } dpps_state_type;

  typedef struct packed {
    logic coreGood;
    logic rstIn;
    logic parkN;
    logic projEn;
    logic hiRes;
    logic fpgaRdy;
  } dpps_pins_type;

  typedef struct packed {
    logic hostIrqOut;
    logic hostIrqOe;
    logic flashOe;
    logic gpioOe;
    logic [1:0] ledSelect;
    logic mirrorArrayResetOut;
    logic parkActive;
    logic regulationOn;
    logic fpgaSetupActive;
    logic i2cAccept;
    logic initDone;
  } dpps_outs_type;

  localparam dpps_pins_type PINS_RST = '0;
  localparam dpps_outs_type OUTS_RST = '0;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;
endpackage

// ==== tb/dpps_partner.sv ====
// Purpose: power controller and host model facing dpps_sequencer
// Assumes: tasks are called from the bench, pins change 1 ns after mclk rises
// Notes: host interrupt wire is pulled up while released
`timescale 1ns/100ps
`default_nettype none
module dpps_partner #(
  parameter int RST_HOLD = 6
)
(
  input wire logic mclk,
  input wire logic hostIrqOut,
  input wire logic hostIrqOe,
  output logic rstIn,
  output logic parkN,
  output logic projEn,
  output logic coreGood,
  output logic fpgaRdy
);
  logic irqLine;
  assign irqLine = hostIrqOe ? hostIrqOut : 1'b1;
  initial
  begin
    rstIn = 1'b0;
    parkN = 1'b1;
    projEn = 1'b0;
    coreGood = 1'b0;
    fpgaRdy = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // supplies up, reset held low, then released
  task automatic power_up();
    step(1);
    // low-power rail shares the core supply, so its order and spacing hold
    coreGood = 1'b1;
    parkN = 1'b1;
    projEn = 1'b1;
    step(RST_HOLD);
    rstIn = 1'b1;
  endtask
  // host drops projector enable; the bench waits for the host interrupt line to go low first
  task automatic normal_park();
    step(1);
    projEn = 1'b0;
  endtask
  task automatic fast_park();
    step(1);
    parkN = 1'b0;
  endtask
  task automatic core_loss();
    step(1);
    coreGood = 1'b0;
  endtask
  // supplies kept valid, then reset asserted
  task automatic shut_down(input int hold);
    step(hold);
    rstIn = 1'b0;
    step(3);
    parkN = 1'b1;
    fpgaRdy = 1'b0;
  endtask
  task automatic fpga_boot(input int delay);
    step(delay);
    fpgaRdy = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/dpps_sequencer_tb.sv ====
// Purpose: self-checking bench for dpps_sequencer
// Assumes: shortened counts, partner model drives the pins
// Notes: each scenario is one task
`timescale 1ns/100ps
`default_nettype none
module dpps_sequencer_tb;
  import dpps_pkg::*;
  localparam int BL = 20;
  localparam int NL = 12;
  localparam int FL = 8;
  localparam int RL = 10;
  localparam int SL = 9;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hiRes = 1'b0;
  logic [1:0] ledReq = 2'h2;
  logic rstIn, parkN, projEn, coreGood, fpgaRdy;
  logic irqOut, irqOe, flashOe, gpioOe, mirror, parkAct, regOn, fSetup, i2cAcc, initDone;
  logic [1:0] ledBits;
  logic [5:0] watch;
  int failCount = 0;
  int checksDone = 0;
  int n;
  assign watch = {dpps_partner_i.irqLine, regOn, i2cAcc, fSetup, parkAct, initDone};
  always #2 mclk = ~mclk;
  dpps_sequencer #(.BOOT_LEN(BL), .NPARK_LEN(NL), .FPARK_LEN(FL), .REG_STOP_LEN(RL),
    .FPGA_SETUP_LEN(SL)) dpps_sequencer_i (.mclk(mclk), .resetn(resetn),
    .activeLowResetIn(rstIn), .fastParkRequestN(parkN), .projectorEnable(projEn),
    .coreSupplyGood(coreGood), .highResolutionMode(hiRes), .fpgaReady(fpgaRdy),
    .ledSelectReq(ledReq), .hostIrqOut(irqOut), .hostIrqOe(irqOe), .flashOe(flashOe),
    .gpioOe(gpioOe), .ledSelectBits(ledBits), .mirrorArrayResetOut(mirror),
    .parkActive(parkAct), .regulationOn(regOn), .fpgaSetupActive(fSetup),
    .i2cAccept(i2cAcc), .initDone(initDone));
  dpps_partner dpps_partner_i (.mclk(mclk), .hostIrqOut(irqOut), .hostIrqOe(irqOe),
    .rstIn(rstIn), .parkN(parkN), .projEn(projEn), .coreGood(coreGood), .fpgaRdy(fpgaRdy));
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failCount++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitOn(input int sel, input logic val, input int bound);
    n = 0;
    while (watch[sel] !== val && n < bound)
    begin
      cyc(1);
      n++;
    end
    if (watch[sel] !== val)
    begin
      failCount++;
      $display("BAD t=%0t wait ran out", $time);
      finalReport();
    end
  endtask
  task automatic tBoot(input logic hiMode);
    hiRes = hiMode;
    dpps_partner_i.power_up();
    cyc(5);
    check(8'({irqOe, irqOut, flashOe, gpioOe, mirror, initDone}), 8'h3e);
    check(8'(ledBits), 8'h2);
    waitOn(0, 1'b1, BL + 6);
    check(8'(n >= BL - 3 && n <= BL + 1), 8'h1);
    check(8'(irqOut), 8'h0);
    check(8'(i2cAcc), 8'(!hiMode));
    if (hiMode)
    begin
      dpps_partner_i.fpga_boot(4);
      waitOn(2, 1'b1, 8);
      waitOn(2, 1'b0, SL + 4);
      check(8'(n >= SL - 2 && n <= SL + 1), 8'h1);
      check(8'(i2cAcc), 8'h1);
    end
  endtask
  task automatic tNormal(input logic hiMode);
    waitOn(5, 1'b0, 300);
    dpps_partner_i.normal_park();
    waitOn(1, 1'b1, 6);
    waitOn(1, 1'b0, NL + 4);
    check(8'(n >= NL - 2 && n <= NL + 1), 8'h1);
    check(8'(mirror), 8'h0);
    check(8'(regOn), 8'(hiMode));
    if (hiMode)
    begin
      waitOn(4, 1'b0, RL + 4);
      check(8'(n >= RL - 2 && n <= RL + 1), 8'h1);
    end
    dpps_partner_i.shut_down(2);
    cyc(1);
    check(8'({irqOe, flashOe, gpioOe, ledBits, mirror}), 8'h0);
    check(8'(watch[5]), 8'h1);
  endtask
  task automatic tFast();
    tBoot(1'b0);
    dpps_partner_i.fast_park();
    waitOn(1, 1'b1, 6);
    check(8'(n <= 4), 8'h1);
    waitOn(1, 1'b0, FL + 4);
    check(8'({mirror, regOn}), 8'h0);
    dpps_partner_i.shut_down(1);
  endtask
  task automatic tCoreLoss();
    tBoot(1'b0);
    dpps_partner_i.core_loss();
    cyc(4);
    check(8'(irqOe), 8'h0);
    dpps_partner_i.shut_down(1);
  endtask
  initial
  begin
    cyc(3);
    resetn = 1'b1;
    cyc(3);
    check(8'({flashOe, gpioOe, ledBits, mirror, irqOe}), 8'h0);
    tBoot(1'b0);
    tNormal(1'b0);
    tBoot(1'b1);
    tNormal(1'b1);
    tFast();
    tCoreLoss();
    finalReport();
  end
endmodule
`default_nettype wire
